// *** core/ivrf_fifo.v ***
// packet queue with registered full, empty and read data
module ivrf_fifo #(
  parameter W  = 16,
  parameter D  = 16,
  parameter AW = 4
) (
  // clock and reset
  input  wire          clk,
  input  wire          reset,
  // fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // drain side
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);

  reg  [W-1:0]  mem [0:D-1];
  reg  [AW-1:0] wr_ptr_r;
  reg  [AW-1:0] rd_ptr_r;
  reg  [AW:0]   count_r;
  reg           full_r;
  reg           empty_r;
  reg  [W-1:0]  data_r;
  wire          push;
  wire          pop;
  wire [AW-1:0] rd_nxt;
  wire [AW:0]   count_nxt;

  assign in_ready  = ~full_r;
  assign out_valid = ~empty_r;
  assign out_data  = data_r;
  assign push      = in_valid & ~full_r;
  assign pop       = out_ready & ~empty_r;
  assign rd_nxt    = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // storage, no reset needed on the array
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and flags; read data is prefetched so it leaves a register
  always @(posedge clk) begin
    if (reset) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
      full_r   <= 1'b0;
      empty_r  <= 1'b1;
      data_r   <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      rd_ptr_r <= rd_nxt;
      count_r  <= count_nxt;
      full_r   <= (count_nxt == D);
      empty_r  <= (count_nxt == {(AW+1){1'b0}});
      // bypass: the word written this cycle may be the next to leave
      if (push && (wr_ptr_r == rd_nxt)) begin
        data_r <= in_data;
      end else begin
        data_r <= mem[rd_nxt];
      end
    end
  end

endmodule

// *** core/ivrf_map.vh ***
// register map, field positions, reset values and timing counts of the forwarder
`ifndef IVRF_MAP_VH
`define IVRF_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define IVRF_OFS_INT      5'h03
`define IVRF_OFS_FRAC     5'h04
`define IVRF_OFS_PKT      5'h05
`define IVRF_OFS_RELOCK   5'h07
`define IVRF_OFS_CALCFG   5'h0A
`define IVRF_OFS_BAND     5'h10

// ----------------------------------------
// packet and control fields
// ----------------------------------------
`define IVRF_ID_HI        2
`define IVRF_ID_LO        0
`define IVRF_IDX_HI       6
`define IVRF_IDX_LO       3
`define IVRF_DATA_HI      15
`define IVRF_DATA_LO      7
`define IVRF_RELOCK_BIT   13
`define IVRF_CAL_OFF_BIT  11
`define IVRF_RATE_HI      14
`define IVRF_RATE_LO      13
`define IVRF_CAL_ACT_BIT  7
`define IVRF_OWN_ID       3'h0
`define IVRF_VREG_BAND    4'h0
`define IVRF_VREG_DIV     4'h2
`define IVRF_DIV2_CODE    4'h6

// ----------------------------------------
// reset values
// ----------------------------------------
`define IVRF_PKT_RST      16'h0000
`define IVRF_RELOCK_RST   16'h0000
`define IVRF_CALCFG_RST   16'h4000
`define IVRF_BAND_RST     8'h00
`define IVRF_DIV_RST      8'h01

// ----------------------------------------
// timing
// ----------------------------------------
`define IVRF_CLK_PS       5000
`define IVRF_LINK_MIN_PS  20000
// shortest link cycle in system clocks: 20 ns at a 5 ns clock, sized to the divider counter
`define IVRF_LINK_MIN_DIV 6'h04
`define IVRF_PKT_BITS     16
`define IVRF_SETTLE_TICKS 6'h20
`define IVRF_FIFO_DEPTH   16

`endif

// *** core/ivrf_top.v ***
// register-write forwarder to the oscillator subsystem with autocalibration control
`include "ivrf_map.vh"

// Behaviour
// - oscillator configuration uses 16-bit serial packets
// - link runs at calibration clock, max 50 MHz
// - packet register write shifts packet out MSB-first
// - bits 2:0 are target id, zero answers
// - bits 6:3 select oscillator register
// - bits 15:7 are the nine-bit value
// - calibration reuses stored id and index unchanged
// - calibration works only with stored id zero
// - integer or fractional write starts calibration
// - packet register write always updates sixteen bits
// - zero packet then divider write forces relock
// - output divider ratios 1 to 128
// - value 0110 into register 2 divides two
// - calibration runs only when bit 11 clear
// - relock enable reruns calibration once on unlock
// - calibration bit selects temperature reference tuning
// - band selects two cores, 128 subbands each
// - device manages calibration bit itself
// - link period is reference times 2^m
// - calibration bit set at start, cleared after
// - oscillator registers write-only, band readable
module ivrf_top (
  // clock and reset
  input  wire        CLK,
  input  wire        RESET,
  // register port
  input  wire        REG_WE,
  input  wire        REG_RE,
  input  wire [4:0]  REG_ADDR,
  input  wire [15:0] REG_WDATA,
  output wire        REG_WREADY,
  output reg  [15:0] REG_RDATA,
  // loop status and mode
  input  wire        FRAC_MODE,
  input  wire        LOCK_LOST,
  input  wire        VCO_FAST,
  // internal oscillator serial link
  output reg         LINK_SCLK,
  output reg         LINK_SEN,
  output reg         LINK_SDATA,
  // oscillator subsystem state
  output reg         CAL_BUSY,
  output reg         TUNE_FROM_REF,
  output reg  [7:0]  OSC_BAND,
  output reg  [7:0]  DIV_RATIO
);

  localparam C_IDLE = 2'd0;
  localparam C_SEND = 2'd1;
  localparam C_WAIT = 2'd2;
  localparam C_LAST = 2'd3;

  // link clock period in system clocks, never faster than 50 MHz
  function [5:0] link_div;
    input [1:0] code;
    reg   [5:0] raw;
    begin
      case (code)
        2'd0:    raw = 6'h01;
        2'd1:    raw = 6'h04;
        2'd2:    raw = 6'h10;
        default: raw = 6'h20;
      endcase
      link_div = (raw < `IVRF_LINK_MIN_DIV) ? `IVRF_LINK_MIN_DIV : raw;
    end
  endfunction

  // divider ratio from the nine-bit value of oscillator register 2
  function [7:0] div_decode;
    input [8:0] v;
    begin
      if (v[3:0] == 4'h1) begin
        div_decode = 8'h01;
      end else if (v[3:0] == `IVRF_DIV2_CODE) begin
        div_decode = 8'h02;
      end else if (v[3:0] == 4'h7) begin
        div_decode = 8'h40;
      end else if (v[3:0] == 4'h8) begin
        div_decode = 8'h80;
      end else if (v[8:4] >= 5'h02 && v[8:4] <= 5'h10) begin
        div_decode = {2'b00, v[8:4], 1'b0};
      end else begin
        div_decode = 8'h02;
      end
    end
  endfunction

  reg  [15:0] pkt_r;
  reg  [15:0] relock_cfg_r;
  reg  [15:0] cal_cfg_r;
  reg  [5:0]  div_cnt_r;
  reg         tick_r;
  reg         mid_r;
  reg         ser_busy_r;
  reg  [15:0] ser_sh_r;
  reg  [3:0]  ser_cnt_r;
  reg  [15:0] rx_sh_r;
  reg  [1:0]  cal_st_r;
  reg  [1:0]  cal_st_nxt;
  reg         cal_req_r;
  reg  [8:0]  cal_data_r;
  reg  [7:0]  band_try_r;
  reg  [2:0]  step_r;
  reg  [5:0]  settle_r;
  reg         start_pend_r;
  reg         relock_arm_r;
  wire        fifo_rdy;
  wire        fifo_vld;
  wire [15:0] fifo_data;
  wire        fifo_pop;
  wire        pkt_wr;
  wire        freq_req;
  wire        relock_req;
  wire        cal_start;
  wire [5:0]  half_div;
  wire [8:0]  rx_val;

  // ----------------------------------------
  // register port
  // ----------------------------------------
  // full packet write
  assign pkt_wr     = REG_WE && (REG_ADDR == `IVRF_OFS_PKT) && fifo_rdy;
  assign freq_req   = REG_WE && !cal_cfg_r[`IVRF_CAL_OFF_BIT] &&
                      (((REG_ADDR == `IVRF_OFS_INT) && !FRAC_MODE) ||
                       ((REG_ADDR == `IVRF_OFS_FRAC) && FRAC_MODE));
  assign REG_WREADY = fifo_rdy;

  // stored copies of the packet and configuration registers
  always @(posedge CLK) begin
    if (RESET) begin
      pkt_r        <= `IVRF_PKT_RST;
      relock_cfg_r <= `IVRF_RELOCK_RST;
      cal_cfg_r    <= `IVRF_CALCFG_RST;
    end else if (REG_WE) begin
      if (pkt_wr) begin
        pkt_r <= REG_WDATA;
      end else if (REG_ADDR == `IVRF_OFS_RELOCK) begin
        relock_cfg_r <= REG_WDATA;
      end else if (REG_ADDR == `IVRF_OFS_CALCFG) begin
        cal_cfg_r <= REG_WDATA;
      end
    end
  end

  // read answer one clock after the strobe; unmapped offsets read zero
  always @(posedge CLK) begin
    if (RESET) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RE) begin
      if (REG_ADDR == `IVRF_OFS_PKT) begin
        REG_RDATA <= pkt_r;
      end else if (REG_ADDR == `IVRF_OFS_RELOCK) begin
        REG_RDATA <= relock_cfg_r;
      end else if (REG_ADDR == `IVRF_OFS_CALCFG) begin
        REG_RDATA <= cal_cfg_r;
      end else if (REG_ADDR == `IVRF_OFS_BAND) begin
        REG_RDATA <= {8'h00, OSC_BAND};
      end else begin
        REG_RDATA <= 16'h0000;
      end
    end
  end

  ivrf_fifo #(
    .W  (16),
    .D  (`IVRF_FIFO_DEPTH),
    .AW (4)
  ) u_fifo (
    .clk       (CLK),
    .reset     (RESET),
    .in_valid  (pkt_wr),
    .in_ready  (fifo_rdy),
    .in_data   (REG_WDATA),
    .out_valid (fifo_vld),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ----------------------------------------
  // link rate divider
  // ----------------------------------------
  // half period from rate field
  assign half_div = link_div(cal_cfg_r[`IVRF_RATE_HI:`IVRF_RATE_LO]) >> 1;

  // tick ends a link cycle, mid raises the link clock halfway through
  always @(posedge CLK) begin
    if (RESET) begin
      div_cnt_r <= 6'h00;
      tick_r    <= 1'b0;
      mid_r     <= 1'b0;
    end else begin
      if (div_cnt_r >= link_div(cal_cfg_r[`IVRF_RATE_HI:`IVRF_RATE_LO]) - 6'h01) begin
        div_cnt_r <= 6'h00;
        tick_r    <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + 6'h01;
        tick_r    <= 1'b0;
      end
      mid_r <= (div_cnt_r == half_div - 6'h01);
    end
  end

  // ----------------------------------------
  // serializer
  // ----------------------------------------
  // calibration traffic takes precedence; host packets wait in the queue
  assign fifo_pop = tick_r && !ser_busy_r && !cal_req_r && fifo_vld;

  always @(posedge CLK) begin
    if (RESET) begin
      ser_busy_r <= 1'b0;
      ser_sh_r   <= 16'h0000;
      ser_cnt_r  <= 4'h0;
      LINK_SEN   <= 1'b0;
      LINK_SDATA <= 1'b0;
      LINK_SCLK  <= 1'b0;
    end else begin
      if (tick_r) begin
        LINK_SCLK <= 1'b0;
        if (!ser_busy_r && (cal_req_r || fifo_vld)) begin
          ser_sh_r   <= cal_req_r ? {cal_data_r, pkt_r[`IVRF_IDX_HI:`IVRF_ID_LO]} : fifo_data;
          LINK_SDATA <= cal_req_r ? cal_data_r[8] : fifo_data[15];
          ser_busy_r <= 1'b1;
          LINK_SEN   <= 1'b1;
          ser_cnt_r  <= 4'hF;
        end else if (ser_busy_r && ser_cnt_r == 4'h0) begin
          ser_busy_r <= 1'b0;
          LINK_SEN   <= 1'b0;
          LINK_SDATA <= 1'b0;
        end else if (ser_busy_r) begin
          ser_sh_r   <= {ser_sh_r[14:0], 1'b0};
          LINK_SDATA <= ser_sh_r[14];
          ser_cnt_r  <= ser_cnt_r - 4'h1;
        end
      end else if (mid_r && ser_busy_r) begin
        LINK_SCLK <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // oscillator subsystem receiver
  // ----------------------------------------
  assign rx_val = rx_sh_r[`IVRF_DATA_HI:`IVRF_DATA_LO];

  // samples on the rising link clock, applies the packet at frame end
  always @(posedge CLK) begin
    if (RESET) begin
      rx_sh_r       <= 16'h0000;
      OSC_BAND      <= `IVRF_BAND_RST;
      TUNE_FROM_REF <= 1'b0;
      DIV_RATIO     <= `IVRF_DIV_RST;
    end else begin
      if (mid_r && ser_busy_r) begin
        rx_sh_r <= {rx_sh_r[14:0], LINK_SDATA};
      end
      if (tick_r && ser_busy_r && ser_cnt_r == 4'h0 &&
          rx_sh_r[`IVRF_ID_HI:`IVRF_ID_LO] == `IVRF_OWN_ID) begin
        if (rx_sh_r[`IVRF_IDX_HI:`IVRF_IDX_LO] == `IVRF_VREG_BAND) begin
          OSC_BAND      <= {rx_val[8], rx_val[6:0]};
          TUNE_FROM_REF <= rx_val[`IVRF_CAL_ACT_BIT];
        end else if (rx_sh_r[`IVRF_IDX_HI:`IVRF_IDX_LO] == `IVRF_VREG_DIV) begin
          DIV_RATIO <= div_decode(rx_val);
        end
      end
    end
  end

  // ----------------------------------------
  // calibration state machine
  // ----------------------------------------
  // single relock attempt
  assign relock_req = LOCK_LOST && relock_cfg_r[`IVRF_RELOCK_BIT] && relock_arm_r &&
                      !cal_cfg_r[`IVRF_CAL_OFF_BIT];
  assign cal_start  = (cal_st_r == C_IDLE) && (start_pend_r || freq_req || relock_req);

  // next state
  always @* begin
    cal_st_nxt = cal_st_r;
    case (cal_st_r)
      C_IDLE: begin
        if (cal_start) begin
          cal_st_nxt = C_SEND;
        end
      end
      C_SEND: begin
        if (!cal_req_r && !ser_busy_r) begin
          cal_st_nxt = C_WAIT;
        end
      end
      C_WAIT: begin
        if (tick_r && settle_r == 6'h00) begin
          cal_st_nxt = (step_r == 3'd0) ? C_LAST : C_SEND;
        end
      end
      default: begin
        if (!cal_req_r && !ser_busy_r) begin
          cal_st_nxt = C_IDLE;
        end
      end
    endcase
  end

  // binary search over core and subband; each trial goes out as a packet
  always @(posedge CLK) begin
    if (RESET) begin
      cal_st_r     <= C_IDLE;
      cal_req_r    <= 1'b0;
      cal_data_r   <= 9'h000;
      band_try_r   <= 8'h00;
      step_r       <= 3'd7;
      settle_r     <= 6'h00;
      start_pend_r <= 1'b0;
      relock_arm_r <= 1'b0;
      CAL_BUSY     <= 1'b0;
    end else begin
      cal_st_r <= cal_st_nxt;
      CAL_BUSY <= (cal_st_nxt != C_IDLE);
      // a request during a run restarts afterwards; set wins over clear
      if (freq_req && cal_st_r != C_IDLE) begin
        start_pend_r <= 1'b1;
      end else if (cal_start) begin
        start_pend_r <= 1'b0;
      end
      // arm again on every host frequency write that requests calibration, spend on a relock
      if (freq_req) begin
        relock_arm_r <= 1'b1;
      end else if (cal_start && relock_req && !start_pend_r) begin
        relock_arm_r <= 1'b0;
      end
      if (tick_r && !ser_busy_r && cal_req_r) begin
        cal_req_r <= 1'b0;
      end
      case (cal_st_r)
        C_IDLE: begin
          if (cal_start) begin
            band_try_r <= 8'h80;
            step_r     <= 3'd7;
            cal_data_r <= {1'b1, 1'b1, 7'h00};
            cal_req_r  <= 1'b1;
          end
        end
        C_SEND: begin
          settle_r <= `IVRF_SETTLE_TICKS;
        end
        C_WAIT: begin
          if (tick_r && settle_r != 6'h00) begin
            settle_r <= settle_r - 6'h01;
          end else if (tick_r) begin
            // bit cleared on the final band
            cal_data_r <= step_r == 3'd0 ?
                          {band_try_r[7] & (VCO_FAST | (step_r != 3'd7)), 1'b0,
                           band_try_r[6:1], band_try_r[0] & VCO_FAST} :
                          {next_band(band_try_r, step_r, VCO_FAST)} ;
            band_try_r <= next_try(band_try_r, step_r, VCO_FAST);
            step_r     <= step_r - 3'd1;
            cal_req_r  <= 1'b1;
          end
        end
        default: begin
          band_try_r <= band_try_r;
        end
      endcase
    end
  end

  // trial band for the next search step: keep or drop the bit under test
  function [7:0] next_try;
    input [7:0] b;
    input [2:0] s;
    input       keep;
    reg   [7:0] r;
    begin
      r = b;
      r[s] = keep;
      if (s != 3'd0) begin
        r[s - 3'd1] = 1'b1;
      end
      next_try = r;
    end
  endfunction

  // packet value of the next trial with the calibration bit held set
  function [8:0] next_band;
    input [7:0] b;
    input [2:0] s;
    input       keep;
    reg   [7:0] r;
    begin
      r = next_try(b, s, keep);
      next_band = {r[7], 1'b1, r[6:0]};
    end
  endfunction

endmodule

// *** tb/ivrf_monitor.sv ***
// concurrent checks on the forwarder's register port, link and oscillator outputs
module ivrf_monitor (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESET,
  // register port
  input wire logic        REG_WE,
  input wire logic        REG_RE,
  input wire logic [4:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_WREADY,
  input wire logic [15:0] REG_RDATA,
  // loop status and mode
  input wire logic        FRAC_MODE,
  input wire logic        LOCK_LOST,
  input wire logic        VCO_FAST,
  // link
  input wire logic        LINK_SCLK,
  input wire logic        LINK_SEN,
  input wire logic        LINK_SDATA,
  // oscillator state
  input wire logic        CAL_BUSY,
  input wire logic        TUNE_FROM_REF,
  input wire logic [7:0]  OSC_BAND,
  input wire logic [7:0]  DIV_RATIO
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] shift_r;
  logic [4:0]  rises_r;
  logic        cal_off_r;
  // shadow of the frame on the wire; counting rises catches a short or long frame
  always @(posedge CLK) begin
    if (RESET) begin
      rises_r   <= 5'h00;
      cal_off_r <= 1'h0;
    end else begin
      if (!LINK_SEN) rises_r <= 5'h00;
      else if ($rose(LINK_SCLK)) rises_r <= rises_r + 5'h01;
      if ($rose(LINK_SCLK)) shift_r <= {shift_r[14:0], LINK_SDATA};
      if (REG_WE && REG_ADDR == 5'h0A) cal_off_r <= REG_WDATA[11];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence frame_end;
    $fell(LINK_SEN);
  endsequence
  sequence trig_write;
    REG_WE && !cal_off_r && !CAL_BUSY && REG_ADDR == (FRAC_MODE ? 5'h04 : 5'h03);
  endsequence
  a_frame_bit_count: assert property (frame_end |-> rises_r == 5'h10)
    else $error("link frame without sixteen clock rises");
  a_clock_idle_low: assert property (!LINK_SEN |-> !LINK_SCLK)
    else $error("link clock moves outside a frame");
  a_data_steady_high: assert property (LINK_SCLK && $past(LINK_SCLK) |-> $stable(LINK_SDATA))
    else $error("link data moved while clock high");
  a_band_read_back: assert property (REG_RE && REG_ADDR == 5'h10 |=> REG_RDATA == {8'h00, $past(OSC_BAND)})
    else $error("band readback differs from band");
  a_divider_reads_zero: assert property (REG_RE && REG_ADDR inside {5'h03, 5'h04} |=> REG_RDATA == 16'h0000)
    else $error("divider register read not zero");
  a_cal_starts: assert property (trig_write |-> ##[1:2] CAL_BUSY)
    else $error("trigger write did not start calibration");
  a_cal_stays_off: assert property (cal_off_r && !CAL_BUSY |=> !CAL_BUSY)
    else $error("calibration ran while disabled");
  a_tune_released: assert property ($fell(CAL_BUSY) |-> ##[0:2] !TUNE_FROM_REF)
    else $error("reference still drives tuning after calibration");
  a_div_two_applied: assert property (frame_end ##0 (shift_r[6:0] == 7'h10 && shift_r[10:7] == 4'h6) |-> ##[1:2] DIV_RATIO == 8'h02)
    else $error("divide-by-two packet not applied");
  a_band_applied: assert property (frame_end ##0 shift_r[6:0] == 7'h00 |-> ##[1:2] OSC_BAND == {shift_r[15], shift_r[13:7]})
    else $error("band packet not applied");
  a_foreign_id_ignored: assert property (frame_end ##0 shift_r[2:0] != 3'h0 |-> $stable(OSC_BAND) && $stable(DIV_RATIO))
    else $error("packet for another id changed state");
endmodule

bind ivrf_top ivrf_monitor ivrf_monitor_inst (.CLK, .RESET, .REG_WE, .REG_RE, .REG_ADDR,
  .REG_WDATA, .REG_WREADY, .REG_RDATA, .FRAC_MODE, .LOCK_LOST, .VCO_FAST, .LINK_SCLK,
  .LINK_SEN, .LINK_SDATA, .CAL_BUSY, .TUNE_FROM_REF, .OSC_BAND, .DIV_RATIO);

// *** tb/ivrf_osc_model.sv ***
// oscillator-side receiver model: collects link frames and answers band comparisons
module ivrf_osc_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // link from the forwarder
  input  wire logic        sclk,
  input  wire logic        sen,
  input  wire logic        sdata,
  // received frame and comparator answer
  output logic             got,
  output logic [15:0]      word,
  output logic [4:0]       nbits,
  output logic             fast
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        sclk_d;
  logic        sen_d;
  logic [15:0] sh;
  initial fast = 1'h0;
  // msb first, one bit per rise
  always @(posedge clk) begin
    sclk_d <= sclk;
    sen_d  <= sen;
    got    <= 1'h0;
    if (rst) begin
      nbits <= 5'h00;
      fast  <= 1'h0;
    end else begin
      if (!sen_d && sen) nbits <= 5'h00;
      if (sen && sclk && !sclk_d) begin
        sh    <= {sh[14:0], sdata};
        nbits <= nbits + 5'h01;
      end
      // comparator answer is the parity of the last frame, so the search branch follows the frame contents
      if (sen_d && !sen) begin
        got  <= 1'h1;
        word <= sh;
        fast <= ^sh;
      end
    end
  end
endmodule

// *** tb/ivrf_tb_top.sv ***
// self-checking bench for the forwarder with a link-side receiver model
module ivrf_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 0, RESET = 1, REG_WE = 0, REG_RE = 0, FRAC_MODE = 0, LOCK_LOST = 0;
  logic [4:0]  REG_ADDR = 0;
  logic [15:0] REG_WDATA = 0, REG_RDATA, word, rv, ncal, q[$];
  logic        REG_WREADY, LINK_SCLK, LINK_SEN, LINK_SDATA, CAL_BUSY, TUNE_FROM_REF, got, fast;
  logic [7:0]  OSC_BAND, DIV_RATIO, eband = 0, ediv = 1;
  logic [4:0]  nbits;
  logic [6:0]  low7 = 0;
  logic        cal_mode = 0, etune = 0, saw_full = 0, tune_seen = 0;
  int          n_mismatch = 0, n_compared = 0, seed = 31, i;
  ivrf_top ivrf_top_inst (.CLK, .RESET, .REG_WE, .REG_RE, .REG_ADDR, .REG_WDATA, .REG_WREADY,
    .REG_RDATA, .FRAC_MODE, .LOCK_LOST, .VCO_FAST(fast), .LINK_SCLK, .LINK_SEN, .LINK_SDATA,
    .CAL_BUSY, .TUNE_FROM_REF, .OSC_BAND, .DIV_RATIO);
  ivrf_osc_model ivrf_osc_model_inst (.clk(CLK), .rst(RESET), .sclk(LINK_SCLK),
    .sen(LINK_SEN), .sdata(LINK_SDATA), .got, .word, .nbits, .fast);
  initial forever #2.5 CLK = ~CLK;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task wrap_up;
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task hang;
    n_mismatch++;
    $display("unexpected wait limit at %0t", $time);
    wrap_up;
  endtask
  // divider ratio that a register-2 value should select
  function automatic logic [7:0] divx(input logic [8:0] v);
    case (v[3:0])
      4'h1: return 8'h01;
      4'h6: return 8'h02;
      4'h7: return 8'h40;
      4'h8: return 8'h80;
      default: return (v[8:4] >= 5'h02 && v[8:4] <= 5'h10) ? {2'h0, v[8:4], 1'h0} : 8'h02;
    endcase
  endfunction
  // packet writes wait for queue room; the frame expectation is queued with the write
  task wr(input logic [4:0] a, input logic [15:0] d);
    int k;
    k = 0;
    @(negedge CLK);
    while (a == 5'h05 && REG_WREADY !== 1'h1) begin
      saw_full = 1;
      if (++k > 2000) hang;
      @(negedge CLK);
    end
    if (a == 5'h05) begin
      q.push_back(d);
      if (d[6:0] == 7'h00) {eband, etune} = {d[15], d[13:7], d[14]};
      if (d[6:0] == 7'h10) ediv = divx(d[15:7]);
    end
    @(posedge CLK);
    REG_WE <= 1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WE <= 0;
  endtask
  task rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge CLK);
    REG_RE <= 1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RE <= 0;
    @(negedge CLK);
    d = REG_RDATA;
  endtask
  task drain;
    int k;
    for (k = 0; q.size() != 0 || CAL_BUSY !== 1'h0; k++) begin
      if (k > 30000) hang;
      @(negedge CLK);
    end
    repeat (4) @(posedge CLK);
  endtask
  // trigger write, then count calibration frames until the machine is idle
  task cal(input logic [4:0] a, input logic [15:0] n, input logic t);
    ncal = 0;
    tune_seen = 0;
    cal_mode = 1;
    wr(a, 16'h1234);
    repeat (3) @(posedge CLK);
    drain;
    chk(ncal, n);
    chk(tune_seen, t);
    chk(TUNE_FROM_REF, 0);
  endtask
  always @(posedge CLK) if (CAL_BUSY === 1'h1 && TUNE_FROM_REF === 1'h1) tune_seen = 1;
  // every frame is whole; outside calibration it matches the oldest queued write
  always @(posedge CLK) if (got) begin
    chk(nbits, 16);
    if (cal_mode) begin
      chk(word[6:0], low7);
      ncal++;
    end else chk(word, q.size() ? q.pop_front() : 16'hXXXX);
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge CLK);
    RESET <= 0;
    rd(5'h05, rv); chk(rv, 16'h0000);
    rd(5'h07, rv); chk(rv, 16'h0000);
    rd(5'h0A, rv); chk(rv, 16'h4000);
    rd(5'h03, rv); chk(rv, 16'h0000);
    rd(5'h10, rv); chk(rv, 16'h0000);
    chk(DIV_RATIO, 8'h01);
    wr(5'h0A, 16'h6000);
    wr(5'h05, 16'h0310);
    drain;
    chk(DIV_RATIO, 8'h02);
    wr(5'h0A, 16'h0000);
    rd(5'h05, rv); chk(rv, 16'h0310);
    // random packets, written faster than the link drains them
    for (i = 0; i < 40; i++) begin
      rv = $random(seed);
      if (rv[8]) rv[2:0] = 3'h0;
      wr(5'h05, rv);
    end
    drain;
    chk(saw_full, 1);
    chk(OSC_BAND, eband);
    chk(TUNE_FROM_REF, etune);
    chk(DIV_RATIO, ediv);
    rd(5'h10, rv); chk(rv, {8'h00, eband});
    // host writes a band packet built from the readback: core bit kept, subband bits 4:0 shifted up one, bit 6 into the calibration bit
    wr(5'h05, {rv[7:6], 1'b0, rv[4:0], 8'h00});
    drain;
    chk(OSC_BAND, eband);
    wr(5'h05, 16'h0000);
    drain;
    cal(5'h03, 9, 1);
    @(posedge CLK);
    FRAC_MODE <= 1;
    cal(5'h03, 0, 0);
    cal(5'h04, 9, 1);
    wr(5'h0A, 16'h0800);
    cal(5'h04, 0, 0);
    wr(5'h0A, 16'h0000);
    wr(5'h07, 16'h2000);
    cal(5'h04, 9, 1);
    cal_mode = 1;
    @(posedge CLK);
    LOCK_LOST <= 1;
    repeat (3) @(posedge CLK);
    drain;
    repeat (200) @(posedge CLK);
    chk(ncal, 18);
    chk(CAL_BUSY, 0);
    @(posedge CLK);
    LOCK_LOST <= 0;
    cal_mode = 0;
    wr(5'h05, 16'h0001);
    drain;
    rv[7:0] = OSC_BAND;
    low7 = 7'h01;
    cal(5'h04, 9, 0);
    chk(OSC_BAND, rv[7:0]);
    wrap_up;
  end
endmodule
